// ==== verilog/pia_pkg.sv ====
// Constants for the interrupt aggregator: map, fields, resets, edge set-up
package pia_pkg;
    localparam int          NGRP          = 4;
    localparam logic [7:0]  ADDR_STATUS   = 8'h00;
    localparam logic [7:0]  ADDR_MASK     = 8'h04;
    localparam logic [7:0]  ADDR_LIVE     = 8'h08;
    localparam logic [7:0]  ADDR_EDGE_A   = 8'h0c;
    localparam logic [7:0]  ADDR_EDGE_B   = 8'h0d;
    localparam logic [7:0]  ADDR_INT_CTRL = 8'h0e;
    localparam logic [7:0]  ADDR_OSC_THM  = 8'h0f;
    localparam logic [7:0]  ADDR_HOLD     = 8'h10;
    localparam logic [7:0]  GRP_ADDR_MSK  = 8'hfc;
    // Control fields
    localparam int          CTRL_CLR_WR   = 0;
    localparam int          CTRL_PEND     = 1;
    localparam int          CTRL_POL_HIGH = 2;
    localparam logic [7:0]  CTRL_RESET    = 8'h02;
    localparam int          OSC_MASK_SLP  = 0;
    localparam logic [7:0]  OSC_RESET     = 8'h00;
    localparam logic [7:0]  MASK_RESET    = 8'h00;
    localparam logic [7:0]  EDGE_RESET    = 8'h00;
    localparam logic [7:0]  HOLD_RESET    = 8'h01;
    localparam logic [7:0]  ALL_ONES      = 8'hff;
    // Source bit positions
    localparam int          B_SUPPLY      = 6;
    localparam int          B_OVERHEAT    = 5;
    localparam int          B_PWR_DOWN    = 4;
    localparam int          B_REMOTE_ON   = 3;
    localparam int          B_HOLD        = 2;
    localparam int          B_BUTTON      = 1;
    localparam int          B_SHORT       = 6;
    localparam int          B_RESET_PIN   = 4;
    localparam int          B_WATCHDOG    = 2;
    // Fixed edge selection for groups one to three
    localparam logic [7:0]  G1_RISE       = 8'h70;
    localparam logic [7:0]  G1_FALL       = 8'h7a;
    localparam logic [7:0]  G1_ALWAYS_ON  = 8'h0a;
    localparam logic [7:0]  G2_RISE       = 8'hff;
    localparam logic [7:0]  G3_RISE       = 8'hff;
    localparam logic [7:0]  NO_EDGE       = 8'h00;
    // Long-press step
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          HOLD_STEP_NS  = 1000000;
    localparam int          HOLD_STEP_CYC = HOLD_STEP_NS / CLK_PERIOD_NS;
    localparam int          HOLD_CNT_W    = 24;
endpackage : pia_pkg

// ==== verilog/pia_aggregator.sv ====
// Interrupt aggregator: event capture, pending store, clear methods, pin
`timescale 1ns/1ps
module pia_aggregator #(
    parameter int HOLD_STEP_CYCLES = pia_pkg::HOLD_STEP_CYC
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    // Event sources, asynchronous levels
    input  wire logic [7:0] src_group1_in,
    input  wire logic [7:0] src_group2_in,
    input  wire logic [7:0] src_group3_in,
    input  wire logic [7:0] src_group4_in,
    // Power state from sequencer
    input  wire logic       device_on_in,
    input  wire logic       sleep_mode_in,
    // Register access from control interface
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       reg_rd_in,
    input  wire logic       reg_wr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    // Outputs
    output logic            int_pin_out,
    output logic            power_on_req_out
);
    import pia_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] raw [NGRP];
    logic [7:0] sync1 [NGRP];
    logic [7:0] sync2 [NGRP];
    logic [7:0] prev [NGRP];
    logic [7:0] status [NGRP];
    logic [7:0] pend [NGRP];
    logic [7:0] next_status [NGRP];
    logic [7:0] next_pend [NGRP];
    logic [7:0] ev [NGRP];
    logic [7:0] clr [NGRP];
    logic [7:0] rise_cfg [NGRP];
    logic [7:0] fall_cfg [NGRP];
    logic [7:0] det_en [NGRP];
    logic [7:0] mask [NGRP];
    logic [7:0] next_mask [NGRP];
    logic [7:0] edge_a, edge_b, ctrl, osc, hold;
    logic [7:0] next_edge_a, next_edge_b, next_ctrl, next_osc, next_hold;
    logic [7:0] next_rdata;
    logic       line_act, line_gated, pon_req, next_int, next_pon;
    logic       stat_hit, clr_try, clr_ok, last_clr, next_last_clr;
    logic [1:0] grp, last_grp, next_last_grp;
    logic [HOLD_CNT_W-1:0] hold_cnt, next_hold_cnt, hold_thr;
    logic       hold_evt;

    assign raw[0] = src_group1_in;
    assign raw[1] = src_group2_in;
    assign raw[2] = src_group3_in;
    assign raw[3] = src_group4_in;
    assign rise_cfg[0] = G1_RISE;
    assign rise_cfg[1] = G2_RISE;
    assign rise_cfg[2] = G3_RISE;
    assign rise_cfg[3] = edge_a;
    assign fall_cfg[0] = G1_FALL;
    assign fall_cfg[1] = NO_EDGE;
    assign fall_cfg[2] = NO_EDGE;
    assign fall_cfg[3] = edge_b;

    ////////////////////////////////////////////////////////////////////////
    // Access decode and clear qualification
    assign grp      = reg_addr_in[1:0];
    assign stat_hit = (reg_addr_in & GRP_ADDR_MSK) == ADDR_STATUS;
    assign clr_try  = stat_hit && (ctrl[CTRL_CLR_WR] ? reg_wr_in : reg_rd_in);
    // Second clear in a row to one register is ignored
    assign clr_ok   = clr_try && !(last_clr && last_grp == grp);

    always_comb begin
        next_last_clr = last_clr;
        next_last_grp = last_grp;
        if (reg_rd_in || reg_wr_in) begin
            next_last_clr = clr_try;
            next_last_grp = grp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Long button hold; counter saturates so one event per press
    assign hold_thr = HOLD_CNT_W'(hold) * HOLD_CNT_W'(HOLD_STEP_CYCLES);
    assign hold_evt = !sync2[0][B_BUTTON] && hold_cnt == hold_thr;

    always_comb begin
        next_hold_cnt = hold_cnt;
        if (sync2[0][B_BUTTON]) begin
            next_hold_cnt = '0;
        end else if (hold_cnt <= hold_thr) begin
            next_hold_cnt = hold_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-group capture
    for (genvar g = 0; g < NGRP; g++) begin : g_grp
        logic [7:0] edges, hold_keep, move;
        // Press-type pins idle high; reset there so release is no false press
        localparam logic [7:0] IDLE_LVL = (g == 0) ? G1_ALWAYS_ON : NO_EDGE;
        // Edges taken from second stage only
        assign edges = (sync2[g] & ~prev[g] & rise_cfg[g])
                     | (~sync2[g] & prev[g] & fall_cfg[g]);
        // Power-on sources ignore the mask but only in active or sleep
        if (g == 0) begin : g_one
            assign det_en[g] = ~mask[g] | G1_ALWAYS_ON;
            assign ev[g] = (edges & ~(device_on_in ? NO_EDGE : G1_ALWAYS_ON)
                           | ({7'h00, hold_evt} << B_HOLD)) & det_en[g];
        end else begin : g_rest
            assign det_en[g] = ~mask[g];
            assign ev[g] = edges & det_en[g];
        end
        assign clr[g] = (clr_ok && grp == 2'(g))
                      ? (ctrl[CTRL_CLR_WR] ? reg_wdata_in : ALL_ONES) : NO_EDGE;
        assign hold_keep = status[g] & ~clr[g];
        assign move      = status[g] & clr[g] & pend[g];

        always_comb begin
            // New events win over clears; pending moves up on clear
            next_status[g] = hold_keep | move | ev[g];
            next_pend[g]   = (pend[g] & ~(status[g] & clr[g]))
                           | (ev[g] & status[g] & (~clr[g] | pend[g])
                              & {8{ctrl[CTRL_PEND] & line_act}});
        end

        always_ff @(posedge clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                sync1[g]  <= IDLE_LVL;
                sync2[g]  <= IDLE_LVL;
                prev[g]   <= IDLE_LVL;
                status[g] <= '0;
                pend[g]   <= '0;
                mask[g]   <= MASK_RESET;
            end else begin
                sync1[g]  <= raw[g];
                sync2[g]  <= sync1[g];
                prev[g]   <= sync2[g];
                status[g] <= next_status[g];
                pend[g]   <= next_pend[g];
                mask[g]   <= next_mask[g];
            end
        end

        a_masked_no_set: assert property (@(posedge clk_in) disable iff (!rst_b_in)
            (!det_en[g][B_PWR_DOWN] && !status[g][B_PWR_DOWN])
            |=> !status[g][B_PWR_DOWN])
            else $error("masked source set status");
        a_masked_stays: assert property (@(posedge clk_in) disable iff (!rst_b_in)
            (status[g][B_SHORT] && mask[g][B_SHORT] && !clr[g][B_SHORT])
            |=> status[g][B_SHORT])
            else $error("set bit lost after masking");
        a_read_clears: assert property (@(posedge clk_in) disable iff (!rst_b_in)
            (clr_ok && grp == 2'(g) && !ctrl[CTRL_CLR_WR] && ev[g] == NO_EDGE
             && pend[g] == NO_EDGE) |=> status[g] == NO_EDGE)
            else $error("clear-on-read left bits");
        a_write_bit: assert property (@(posedge clk_in) disable iff (!rst_b_in)
            (clr[g][B_WATCHDOG] && !ev[g][B_WATCHDOG] && !pend[g][B_WATCHDOG])
            |=> !status[g][B_WATCHDOG])
            else $error("cleared bit still set");
        a_pending_two: assert property (@(posedge clk_in) disable iff (!rst_b_in)
            (status[g][B_HOLD] && pend[g][B_HOLD] && clr[g][B_HOLD] && !ev[g][B_HOLD])
            |=> (status[g][B_HOLD] && !pend[g][B_HOLD]))
            else $error("pending bit not kept");
        a_no_pend_discard: assert property (@(posedge clk_in) disable iff (!rst_b_in)
            (!ctrl[CTRL_PEND] && !pend[g][B_SUPPLY]) |=> !pend[g][B_SUPPLY])
            else $error("pending stored while disabled");
        // New events always land, even with the line already active
        a_event_lands: assert property (@(posedge clk_in) disable iff (!rst_b_in)
            ev[g][B_RESET_PIN] |=> status[g][B_RESET_PIN])
            else $error("event not recorded");
        a_pend_needs_line: assert property (@(posedge clk_in) disable iff (!rst_b_in)
            !line_act |=> (pend[g] & ~$past(pend[g])) == NO_EDGE)
            else $error("pending stored with line idle");
    end

    ////////////////////////////////////////////////////////////////////////
    // Output line and power-on request
    always_comb begin
        line_act = 1'b0;
        pon_req  = 1'b0;
        for (int g = 0; g < NGRP; g++) begin
            line_act = line_act | (|(status[g] & ~mask[g]));
        end
        pon_req    = line_act | (|(status[0] & G1_ALWAYS_ON));
        line_gated = line_act && !(sleep_mode_in && osc[OSC_MASK_SLP]);
        next_int   = ctrl[CTRL_POL_HIGH] ? line_gated : !line_gated;
        next_pon   = pon_req;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes and reads
    always_comb begin
        next_mask   = mask;
        next_edge_a = edge_a;
        next_edge_b = edge_b;
        next_ctrl   = ctrl;
        next_osc    = osc;
        next_hold   = hold;
        next_rdata  = reg_rdata_out;
        if (reg_wr_in) begin
            if ((reg_addr_in & GRP_ADDR_MSK) == ADDR_MASK) begin
                next_mask[grp] = reg_wdata_in;
            end else if (reg_addr_in == ADDR_EDGE_A) begin
                next_edge_a = reg_wdata_in;
            end else if (reg_addr_in == ADDR_EDGE_B) begin
                next_edge_b = reg_wdata_in;
            end else if (reg_addr_in == ADDR_INT_CTRL) begin
                next_ctrl = reg_wdata_in;
            end else if (reg_addr_in == ADDR_OSC_THM) begin
                next_osc = reg_wdata_in;
            end else if (reg_addr_in == ADDR_HOLD) begin
                next_hold = reg_wdata_in;
            end
        end
        if (reg_rd_in) begin
            if (stat_hit) begin
                next_rdata = status[grp];
            end else if ((reg_addr_in & GRP_ADDR_MSK) == ADDR_MASK) begin
                next_rdata = mask[grp];
            end else if ((reg_addr_in & GRP_ADDR_MSK) == ADDR_LIVE) begin
                next_rdata = sync2[grp];
            end else if (reg_addr_in == ADDR_EDGE_A) begin
                next_rdata = edge_a;
            end else if (reg_addr_in == ADDR_EDGE_B) begin
                next_rdata = edge_b;
            end else if (reg_addr_in == ADDR_INT_CTRL) begin
                next_rdata = ctrl;
            end else if (reg_addr_in == ADDR_OSC_THM) begin
                next_rdata = osc;
            end else if (reg_addr_in == ADDR_HOLD) begin
                next_rdata = hold;
            end else begin
                next_rdata = NO_EDGE;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            edge_a           <= EDGE_RESET;
            edge_b           <= EDGE_RESET;
            ctrl             <= CTRL_RESET;
            osc              <= OSC_RESET;
            hold             <= HOLD_RESET;
            reg_rdata_out    <= '0;
            int_pin_out      <= 1'b1;
            power_on_req_out <= 1'b0;
            last_clr         <= 1'b0;
            last_grp         <= '0;
            hold_cnt         <= '0;
        end else begin
            edge_a           <= next_edge_a;
            edge_b           <= next_edge_b;
            ctrl             <= next_ctrl;
            osc              <= next_osc;
            hold             <= next_hold;
            reg_rdata_out    <= next_rdata;
            int_pin_out      <= next_int;
            power_on_req_out <= next_pon;
            last_clr         <= next_last_clr;
            last_grp         <= next_last_grp;
            hold_cnt         <= next_hold_cnt;
        end
    end

    a_pin_level: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        line_gated |=> int_pin_out == $past(ctrl[CTRL_POL_HIGH]))
        else $error("pin not asserted with pending status");
    a_idle_drops: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (!line_act && !ctrl[CTRL_POL_HIGH] && $stable(ctrl)) |=> int_pin_out)
        else $error("pin active with all status clear");
    // A refused clear must leave its group untouched
    a_twice_once: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (clr_try && last_clr && last_grp == grp && ev[grp] == NO_EDGE)
        |=> status[$past(grp)] == $past(status[grp]))
        else $error("back-to-back clear accepted");
    a_button_req: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        status[0][B_BUTTON] |=> power_on_req_out)
        else $error("button status without on-request");

    ////////////////////////////////////////////////////////////////////////
    // Sleep gating, on-request, long hold and read-back
    a_sleep_quiet: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (sleep_mode_in && osc[OSC_MASK_SLP]) |=> int_pin_out != $past(ctrl[CTRL_POL_HIGH]))
        else $error("pin signalled in sleep while suppressed");
    a_line_on_req: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        line_act |=> power_on_req_out)
        else $error("active line without on-request");
    a_hold_single: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        hold_evt |=> !hold_evt)
        else $error("long hold raised twice");
    a_dev_off: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (!device_on_in && !status[0][B_REMOTE_ON]) |=> !status[0][B_REMOTE_ON])
        else $error("remote power-on taken while off");
    a_live_read: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (reg_rd_in && (reg_addr_in & GRP_ADDR_MSK) == ADDR_LIVE) |=> reg_rdata_out == $past(sync2[grp]))
        else $error("live level read wrong");
    a_status_read: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (reg_rd_in && stat_hit) |=> reg_rdata_out == $past(status[grp]))
        else $error("status read wrong");
endmodule : pia_aggregator

// ==== bench/pia_host.sv ====
// Host model: register accesses over the control port
`timescale 1ns/1ps
module pia_host (
    // Clock
    input  wire logic       clk_in,
    // Register port
    output logic      [7:0] reg_addr_out,
    output logic            reg_rd_out,
    output logic            reg_wr_out,
    output logic      [7:0] reg_wdata_out,
    input  wire logic [7:0] reg_rdata_in
);
    initial begin
        reg_addr_out  = 8'h00;
        reg_rd_out    = 1'b0;
        reg_wr_out    = 1'b0;
        reg_wdata_out = 8'h00;
    end
    // Request held up to the taking edge, then buses scrambled
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_in);
        reg_addr_out  <= a;
        reg_wdata_out <= d;
        reg_rd_out    <= ~w;
        reg_wr_out    <= w;
        @(posedge clk_in);
        reg_rd_out    <= 1'b0;
        reg_wr_out    <= 1'b0;
        reg_addr_out  <= ~a;
        reg_wdata_out <= ~d;
        #1 q = reg_rdata_in;
    endtask : access
endmodule : pia_host

// ==== bench/tb_top.sv ====
// Self-checking bench for the interrupt aggregator
`timescale 1ns/1ps
module tb_top;
    import pia_pkg::*;
    logic       clk_in   = 1'b0;
    logic       rst_b_in = 1'b0;
    logic       slp      = 1'b0;
    logic       dev_on   = 1'b1;
    logic [7:0] src [4]  = '{G1_ALWAYS_ON, 8'h00, 8'h00, 8'h00};
    logic [7:0] addr, wdata, rdata, got;
    logic       rd, wr, pin, pon;
    int         n_errors = 0;
    int         n_tests  = 0;
    int         cycles   = 0;
    int         st [4], pd [4], mk [4];
    int         ctrl, osc, ea, eb, lastclr, b;

    always #12.5 clk_in = ~clk_in;

    pia_aggregator #(.HOLD_STEP_CYCLES(4)) i_pia_aggregator (
        .clk_in(clk_in), .rst_b_in(rst_b_in),
        .src_group1_in(src[0]), .src_group2_in(src[1]), .src_group3_in(src[2]), .src_group4_in(src[3]),
        .device_on_in(dev_on), .sleep_mode_in(slp),
        .reg_addr_in(addr), .reg_rd_in(rd), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .int_pin_out(pin), .power_on_req_out(pon));

    pia_host i_pia_host (.clk_in(clk_in), .reg_addr_out(addr), .reg_rd_out(rd), .reg_wr_out(wr),
        .reg_wdata_out(wdata), .reg_rdata_in(rdata));

    ////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////
    function automatic bit line();
        return ((st[0] & ~mk[0]) | (st[1] & ~mk[1]) | (st[2] & ~mk[2]) | (st[3] & ~mk[3])) != 0;
    endfunction : line

    function automatic void m_ev(int g, int i);
        if (mk[g][i] && !(g == 0 && G1_ALWAYS_ON[i])) return;
        if (!st[g][i]) st[g][i] = 1;
        else if (line() && ctrl[1]) pd[g][i] = 1;
    endfunction : m_ev

    function automatic void m_clr(int g, int bits);
        if (lastclr == g) return;
        lastclr = g;
        for (int i = 0; i < 8; i++)
            if (bits[i]) begin
                if (pd[g][i]) pd[g][i] = 0;
                else st[g][i] = 0;
            end
    endfunction : m_clr

    task automatic acc(input logic w, input int a, input int d);
        int e;
        e = a < 4 ? st[a] : a < 8 ? mk[a - 4] : a < 12 ? int'(src[a - 8]) : a == 12 ? ea : a == 13 ? eb
          : a == 14 ? ctrl : a == 15 ? osc : a == 16 ? 1 : 0;
        i_pia_host.access(w, 8'(a), 8'(d), got);
        if (!w) chk("rdata", got, 8'(e));
        if (a < 4 && w == ctrl[0]) m_clr(a, w ? d : 255);
        else begin
            lastclr = -1;
            if (w && a >= 4 && a < 8) mk[a - 4] = d;
            if (w && a == 12) ea = d;
            if (w && a == 13) eb = d;
            if (w && a == 14) ctrl = d;
            if (w && a == 15) osc = d;
        end
        @(posedge clk_in);
        #1 chk("int_pin", 8'(pin), 8'(!((line() && !(osc[0] && slp)) ^ ctrl[2])));
        chk("power_on_req", 8'(pon), 8'(line() || (st[0] & G1_ALWAYS_ON) != 0));
    endtask : acc

    // Rise, settle, fall, settle; edges qualify per group
    task automatic pulse(input int g, input int i);
        @(posedge clk_in);
        src[g][i] <= 1'b1;
        repeat (5) @(posedge clk_in);
        if (g == 3 ? ea[i] : g > 0) m_ev(g, i);
        acc(0, 8 + g, 0);
        @(posedge clk_in);
        src[g][i] <= 1'b0;
        repeat (5) @(posedge clk_in);
        if (g == 3 && eb[i]) m_ev(g, i);
    endtask : pulse

    ////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(1371));
        st = '{default: 0};
        pd = '{default: 0};
        mk = '{default: 0};
        ctrl = CTRL_RESET;
        osc = 0;
        ea = 0;
        eb = 0;
        lastclr = -1;
        b = $urandom % 8;
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        for (int a = 0; a <= 16; a++) acc(0, a, 0);
        acc(0, 32, 0);
        // Two groups, cleared one by one
        pulse(1, B_SHORT);
        pulse(2, b);
        acc(0, 1, 0);
        acc(0, 2, 0);
        // Repeats stored once; back-to-back read ignored
        repeat (3) pulse(2, b);
        acc(0, 2, 0);
        acc(0, 2, 0);
        acc(0, 0, 0);
        acc(0, 2, 0);
        acc(0, 0, 0);
        acc(0, 2, 0);
        // Mask after set, then masked events
        pulse(2, b);
        acc(1, 6, 1 << b);
        pulse(2, b);
        acc(0, 2, 0);
        pulse(2, b);
        acc(0, 2, 0);
        acc(1, 6, 0);
        // Clear-on-write, no pending store
        acc(1, 14, 1);
        pulse(1, B_SHORT);
        repeat (2) pulse(1, B_RESET_PIN);
        pulse(1, B_WATCHDOG);
        acc(1, 1, 1 << B_RESET_PIN);
        acc(0, 1, 0);
        acc(1, 1, ALL_ONES);
        // Active-high pin, edge selects of the fourth group
        acc(1, 14, 4);
        acc(1, 13, 1);
        pulse(3, 0);
        pulse(3, 1);
        acc(1, 12, 2);
        pulse(3, 1);
        acc(0, 3, 0);
        // Group one: button requests power-on even when masked; hold event obeys mask
        acc(1, 4, ALL_ONES);
        @(posedge clk_in);
        src[0][B_BUTTON] <= 1'b0;
        repeat (12) @(posedge clk_in);
        m_ev(0, B_BUTTON);
        m_ev(0, B_HOLD);
        acc(0, 12, 0);
        acc(0, 0, 0);
        @(posedge clk_in);
        src[0][B_BUTTON] <= 1'b1;
        acc(1, 4, 0);
        @(posedge clk_in);
        src[0][B_BUTTON] <= 1'b0;
        repeat (12) @(posedge clk_in);
        m_ev(0, B_BUTTON);
        m_ev(0, B_HOLD);
        acc(0, 12, 0);
        acc(0, 0, 0);
        // Device off: remote power-on edge ignored
        @(posedge clk_in);
        dev_on <= 1'b0;
        src[0][B_BUTTON] <= 1'b1;
        src[0][B_REMOTE_ON] <= 1'b0;
        repeat (6) @(posedge clk_in);
        acc(0, 0, 0);
        @(posedge clk_in);
        dev_on <= 1'b1;
        src[0][B_REMOTE_ON] <= 1'b1;
        // Pin quiet in sleep while request stands
        acc(1, 15, 1);
        @(posedge clk_in);
        slp <= 1'b1;
        pulse(2, b);
        acc(0, 2, 0);
        print_verdict();
    end
endmodule : tb_top
